// ---- rtl/apalu_core.sv ----
/*
  Add and pointer datapath with its AHB-Lite register slave.
  Assumes a single AHB-Lite master issuing single word transfers;
  one instruction cycle equals one core_clk cycle.
*/
// Behaviour
// [RULE1] Pointer add sign-extends 6-bit literal, adds to chosen pointer, flags untouched.
// [RULE2] Pointer sum wraps modulo 65536, never saturates or flags.
// [RULE3] Literal add puts accumulator plus 8-bit literal into accumulator, updates flags.
// [RULE4] File add sums accumulator and file byte; dest bit picks accumulator or file.
// [RULE5] Program counter changes or true tests take two cycles, second idle.
// [RULE6] Window access with pointer top bit set costs one extra cycle.
// [RULE7] Window access goes through pointer; window-to-window reads zero, writes dropped.
// [RULE8] Carry from bit 7, half carry from bit 3, zero when result is zero.
`timescale 1ns/1ps
module apalu_core
  import apalu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             execBusy
);
  import apalu_pkg::*;

  logic [7:0]  acc;
  logic [2:0]  flags;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic [31:0] cmd;
  logic        go;
  logic [1:0]  busyCnt;
  logic [1:0]  lastCycles;
  logic [7:0]  fileMem [0:127];
  logic        dpWrite;
  logic [11:0] dpIdx;
  logic        rdWait;

  // Address phase decode; upper address bits must be zero to hit
  wire        addrTaken = hsel & hready & htrans[1];
  wire        addrHit   = (haddr[31:IDX_MSB+1] == '0);
  wire [11:0] busIdx    = haddr[IDX_MSB:IDX_LSB];

  // Data phase decode
  wire wrFile   = dpWrite & (dpIdx <= IDX_FILE_TOP);
  wire wrWin    = dpWrite & ((dpIdx == IDX_WINDOW0) | (dpIdx == IDX_WINDOW1));
  wire wrFlags  = dpWrite & (dpIdx == IDX_FLAGS);
  wire wrPtr0   = dpWrite & (dpIdx == IDX_POINTER0);
  wire wrPtr1   = dpWrite & (dpIdx == IDX_POINTER1);
  wire wrAcc    = dpWrite & (dpIdx == IDX_ACC);
  wire wrCmd    = dpWrite & (dpIdx == IDX_COMMAND) & ~execBusy;

  // Command fields
  wire [1:0]  opCode = cmd[CMD_OP_LSB +: 2];
  wire        dest   = cmd[CMD_DEST];
  wire        ptrSel = cmd[CMD_PTR_SEL];
  wire [7:0]  lit8   = cmd[CMD_LIT_LSB +: 8];
  wire [5:0]  lit6   = cmd[CMD_LIT_LSB +: 6];
  wire [6:0]  fAddr  = cmd[CMD_FILE_LSB +: 7];
  wire        opLit  = (opCode == OP_ADD_LIT_ACC);
  wire        opFile = (opCode == OP_ADD_ACC_FILE);
  wire        opPtr  = (opCode == OP_ADD_LIT_PTR);
  wire        opPc   = (opCode == OP_PC_MODIFY);

  // [RULE7] Window redirect through pointer
  wire        isWin    = (fAddr == FILE_WINDOW0) | (fAddr == FILE_WINDOW1);
  wire [15:0] winPtr   = fAddr[0] ? ptr1 : ptr0;
  wire        effIsWin = (winPtr < BANKED_LIMIT) & (winPtr[6:1] == FILE_WINDOW0[6:1]);
  wire [6:0]  effAddr  = isWin ? winPtr[6:0] : fAddr;
  wire        wrDrop   = isWin & effIsWin;
  wire [7:0]  fileRd   = wrDrop ? 8'h00 : fileMem[effAddr];

  // [RULE3] [RULE4] Operand select and sum
  wire [7:0]  addB  = opLit ? lit8 : fileRd;
  wire [8:0]  sum9  = {1'b0, acc} + {1'b0, addB};
  wire [4:0]  half5 = {1'b0, acc[3:0]} + {1'b0, addB[3:0]};
  wire        toAcc = opLit | (opFile & ~dest);
  wire        toMem = opFile & dest & ~wrDrop;

  // [RULE1] [RULE2] Sign extension; 16-bit sum drops the carry, so it wraps
  wire [15:0] ptrSel16 = ptrSel ? ptr1 : ptr0;
  wire [15:0] ptrSum   = ptrSel16 + {{10{lit6[5]}}, lit6};

  // [RULE5] [RULE6] Cycle cost of the instruction in flight
  wire        extra     = opFile & isWin & winPtr[15];
  wire [1:0]  cycles    = CYCLES_ONE + {1'b0, opPc} + {1'b0, extra};

  // Bus view of the indirect windows
  wire [15:0] busPtr   = dpIdx[0] ? ptr1 : ptr0;
  wire        busWinWin = (busPtr < BANKED_LIMIT) & (busPtr[6:1] == FILE_WINDOW0[6:1]);

  wire [7:0]  fileBus  = fileMem[dpIdx[6:0]];
  wire [7:0]  winBus   = busWinWin ? 8'h00 : fileMem[busPtr[6:0]];
  wire [31:0] rdMux =
      (dpIdx <= IDX_FILE_TOP)      ? {24'h00_0000, fileBus} :
      (dpIdx == IDX_WINDOW0)       ? {24'h00_0000, winBus} :
      (dpIdx == IDX_WINDOW1)       ? {24'h00_0000, winBus} :
      (dpIdx == IDX_FLAGS)         ? {29'h0, flags} :
      (dpIdx == IDX_POINTER0)      ? {16'h0000, ptr0} :
      (dpIdx == IDX_POINTER1)      ? {16'h0000, ptr1} :
      (dpIdx == IDX_ACC)           ? {24'h00_0000, acc} :
      (dpIdx == IDX_COMMAND)       ? cmd :
      (dpIdx == IDX_EXEC_STAT)     ? {28'h000_0000, lastCycles, 1'b0, execBusy} :
                                     32'h0000_0000;

  assign execBusy  = go | (busyCnt != 2'h0);
  assign hreadyout = ~rdWait;
  assign hresp     = 1'b0;

  // Bus phase tracking; reads get one wait state so hrdata is a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dpWrite <= 1'b0;
      dpIdx   <= 12'h000;
      rdWait  <= 1'b0;
      hrdata  <= 32'h0000_0000;
    end else if (rdWait) begin
      rdWait <= 1'b0;
      hrdata <= rdMux;
    end else begin
      dpWrite <= addrTaken & hwrite & addrHit;
      rdWait  <= addrTaken & ~hwrite;
      dpIdx   <= addrHit ? busIdx : 12'hFFF;
    end
  end

  // Command launch; writes while busy are dropped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd <= 32'h0000_0000;
      go  <= 1'b0;
    end else begin
      go <= wrCmd;
      if (wrCmd) begin
        cmd <= hwdata;
      end
    end
  end

  // [RULE5] [RULE6] Hold busy for the extra idle cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busyCnt    <= 2'h0;
      lastCycles <= 2'h0;
    end else if (go) begin
      busyCnt    <= cycles - CYCLES_ONE;
      lastCycles <= cycles;
    end else if (busyCnt != 2'h0) begin
      busyCnt <= busyCnt - CYCLES_ONE;
    end
  end

  // [RULE3] [RULE4] Accumulator; execution beats a bus write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc <= ACC_RESET;
    end else if (go & toAcc) begin
      acc <= sum9[7:0];
    end else if (wrAcc) begin
      acc <= hwdata[7:0];
    end
  end

  // [RULE8] Flags follow every 8-bit add, pointer add leaves them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags <= FLAGS_RESET;
    end else if (go & (opLit | opFile)) begin
      flags[FLAG_CARRY] <= sum9[8];
      flags[FLAG_HALF]  <= half5[4];
      flags[FLAG_ZERO]  <= (sum9[7:0] == 8'h00);
    end else if (wrFlags) begin
      flags <= hwdata[2:0];
    end
  end

  // [RULE1] [RULE2] Pointer pair update
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptr0 <= PTR_RESET;
      ptr1 <= PTR_RESET;
    end else begin
      if (go & opPtr & ~ptrSel) ptr0 <= ptrSum;
      else if (wrPtr0)          ptr0 <= hwdata[15:0];
      if (go & opPtr & ptrSel)  ptr1 <= ptrSum;
      else if (wrPtr1)          ptr1 <= hwdata[15:0];
    end
  end

  // [RULE7] File array; no reset since it models plain data memory
  always_ff @(posedge core_clk) begin
    if (go & toMem) begin
      fileMem[effAddr] <= sum9[7:0];
    end else if (wrFile) begin
      fileMem[dpIdx[6:0]] <= hwdata[7:0];
    end else if (wrWin & ~busWinWin) begin
      fileMem[busPtr[6:0]] <= hwdata[7:0];
    end
  end

  // Checks on the datapath
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_ptr_wrap: assert property (go & opPtr |=> (ptrSel ? ptr1 : ptr0) == $past(ptrSum)) // [RULE2]
    else $error("pointer sum not wrapped");
  a_ptr_flags: assert property (go & opPtr & ~wrFlags |=> $stable(flags)) // [RULE1]
    else $error("pointer add changed flags");
  a_lit_acc: assert property (go & opLit |=> acc == $past(acc) + $past(lit8)) // [RULE3]
    else $error("literal add result wrong");
  a_zero_flag: assert property (go & (opLit | opFile) |=>
      flags[FLAG_ZERO] == ($past(sum9[7:0]) == 8'h00)) // [RULE8]
    else $error("zero flag wrong");
  a_carry_flags: assert property (go & (opLit | opFile) |=>
      flags[FLAG_CARRY] == $past(sum9[8]) && flags[FLAG_HALF] == $past(half5[4])) // [RULE8]
    else $error("carry flags wrong");
  a_branch_two: assert property (go & opPc |=> execBusy ##1 !execBusy) // [RULE5]
    else $error("pc modify not two cycles");
  a_ind_extra: assert property (go & opFile |=> execBusy == $past(extra)) // [RULE6]
    else $error("indirect extra cycle wrong");
  a_win_zero: assert property (go & opFile & wrDrop & ~dest |=> acc == $past(acc)) // [RULE7]
    else $error("window self read not zero");
  a_file_dest: assert property (go & opFile & dest & ~wrAcc |=> $stable(acc)) // [RULE4]
    else $error("file dest touched accumulator");
  a_rd_wait: assert property (addrTaken & ~hwrite & ~rdWait |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_lit_carry: cover property (go & opLit & sum9[8]);
  c_ptr_wrap:  cover property (go & opPtr & lit6[5] & (ptrSel16 == 16'h0000));
  c_ind_extra: cover property (go & opFile & extra);
  c_win_drop:  cover property (go & opFile & wrDrop & dest);
endmodule : apalu_core

// ---- rtl/apalu_pkg.sv ----
/*
  Constants shared by the add and pointer datapath: register indices,
  command fields, flag positions and reset values.
  Assumes one 32-bit AHB-Lite word per register index.
*/
package apalu_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_WINDOW0  = 12'h600;
  localparam logic [11:0] IDX_WINDOW1  = 12'h601;
  localparam logic [11:0] IDX_FLAGS    = 12'h603;
  localparam logic [11:0] IDX_POINTER0 = 12'h604;
  localparam logic [11:0] IDX_POINTER1 = 12'h606;
  localparam logic [11:0] IDX_ACC      = 12'h609;
  localparam logic [11:0] IDX_COMMAND  = 12'h610;
  localparam logic [11:0] IDX_EXEC_STAT = 12'h611;
  localparam logic [11:0] IDX_FILE_TOP = 12'h07F;  // File array at indices 0..127
  localparam int          IDX_LSB      = 2;
  localparam int          IDX_MSB      = 13;

  // Flag bit positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF  = 1;
  localparam int FLAG_ZERO  = 2;

  // Command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_DEST     = 2;
  localparam int CMD_PTR_SEL  = 3;
  localparam int CMD_LIT_LSB  = 8;
  localparam int CMD_FILE_LSB = 16;

  // Indirect window addresses inside the 7-bit file space
  localparam logic [6:0]  FILE_WINDOW0 = 7'h00;
  localparam logic [6:0]  FILE_WINDOW1 = 7'h01;
  // Pointer values below this limit address the banked space
  localparam logic [15:0] BANKED_LIMIT = 16'h1000;

  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  localparam logic [2:0]  FLAGS_RESET = 3'h0;
  localparam logic [1:0]  CYCLES_ONE  = 2'h1;

  typedef enum logic [1:0] {
    OP_ADD_LIT_ACC  = 2'b00,
    OP_ADD_ACC_FILE = 2'b01,
    OP_ADD_LIT_PTR  = 2'b10,
    OP_PC_MODIFY    = 2'b11
  } apalu_op_e;
endpackage : apalu_pkg

// ---- verif/apalu_core_test.sv ----
/*
  Self-checking bench for apalu_core: literal, file and pointer adds,
  instruction timing and indirect windows, driven over AHB-Lite.
  Assumes the slave answers writes at once and reads after one wait.
*/
`timescale 1ns/1ps
module apalu_core_test;
  import apalu_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic [1:0]  htrans   = 2'h0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, execBusy;
  logic [7:0]  a, b;
  logic [10:0] e;
  logic [15:0] p;
  logic [5:0]  k;
  logic [6:0]  f;
  logic [15:0] corner [4] = '{16'h01ff, 16'h0f01, 16'h8080, 16'h0000};
  logic [29:0] pcase [3] = '{{16'hffff, 6'h01, 8'h01}, {16'h0000, 6'h20, 8'h02},
                            {16'h7fff, 6'h1f, 8'h07}};
  int          fail_count = 0, checked = 0, cyc = 0, seed = 32'ha3867fad;

  // Single slave, so its ready is the bus ready
  apalu_core DUT (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .execBusy(execBusy));

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Sample ready before the edge so the edge's own updates never race us
  task automatic rdy();
    @(negedge core_clk);
    for (int n = 0; n < 16 && hreadyout !== 1'b1; n++) @(negedge core_clk);
    // A slave that never answers counts against the run
    if (hreadyout !== 1'b1) fail_count++;
    rd = hrdata;
    @(posedge core_clk);
  endtask : rdy

  task automatic bus(input logic w, input logic [11:0] i, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {18'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
  endtask : bus

  task automatic rdchk(input logic [11:0] i, input logic [31:0] exp);
    bus(1'b0, i, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : rdchk

  // Start a command and count the cycles the core stays busy
  task automatic run(input logic [31:0] c);
    bus(1'b1, IDX_COMMAND, c);
    cyc = 0;
    @(negedge core_clk);
    while (execBusy === 1'b1 && cyc < 8) begin
      cyc++;
      @(negedge core_clk);
    end
    if (execBusy !== 1'b0) fail_count++;
  endtask : run

  // Expected {zero, half carry, carry, sum}
  function automatic logic [10:0] add8(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    logic       h;
    s = x + y;
    h = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f;
    return {s[7:0] == 8'h00, h, s[8], s[7:0]};
  endfunction : add8

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Watchdog, far beyond the roughly 1200 cycles the tests need
  initial begin
    #100000;
    fail_count++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk(IDX_ACC, 32'h0000_0000);
    rdchk(IDX_POINTER1, 32'h0000_0000);
    bus(1'b1, 12'h080, 32'h0000_00a5);
    rdchk(12'h080, 32'h0000_0000);
    $display("reset and unmapped test done");
    for (int n = 0; n < 24; n++) begin
      {a, b} = (n < 4) ? corner[n] : 16'($random(seed));
      e = add8(a, b);
      bus(1'b1, IDX_ACC, {24'h0, a});
      bus(1'b1, IDX_FLAGS, {29'h0, ~e[10:8]});
      run({16'h0, b, 8'h00});
      chk(cyc, 32'h0000_0001);
      rdchk(IDX_ACC, {24'h0, e[7:0]});
      rdchk(IDX_FLAGS, {29'h0, e[10:8]});
    end
    $display("literal add test done");
    for (int n = 0; n < 16; n++) begin
      {a, b, f, k} = 29'($random(seed));
      if (n == 0 || f < 7'h02) f = IDX_FILE_TOP[6:0];
      e = add8(a, b);
      bus(1'b1, {5'h0, f}, {24'h0, b});
      bus(1'b1, IDX_ACC, {24'h0, a});
      run({9'h0, f, 8'h0, 5'h0, k[0], 2'b01});
      rdchk(IDX_ACC, {24'h0, k[0] ? a : e[7:0]});
      rdchk({5'h0, f}, {24'h0, k[0] ? e[7:0] : b});
      rdchk(IDX_FLAGS, {29'h0, e[10:8]});
    end
    $display("file add test done");
    for (int n = 0; n < 16; n++) begin
      {p, k, a} = (n < 3) ? pcase[n] : 30'($random(seed));
      bus(1'b1, a[0] ? IDX_POINTER1 : IDX_POINTER0, {16'h0, p});
      bus(1'b1, IDX_FLAGS, {29'h0, a[3:1]});
      run({16'h0, 2'b00, k, 4'h0, a[0], 3'b010});
      rdchk(a[0] ? IDX_POINTER1 : IDX_POINTER0, {16'h0, p + {{10{k[5]}}, k}});
      rdchk(IDX_FLAGS, {29'h0, a[3:1]});
    end
    $display("pointer add test done");
    run(32'h0000_0003);
    chk(cyc, 32'h0000_0002);
    rdchk(IDX_EXEC_STAT, 32'h0000_0008);
    $display("branch timing test done");
    // Window through a pointer with its top bit set, then one without
    bus(1'b1, 12'h010, 32'h0000_0033);
    bus(1'b1, IDX_POINTER0, 32'h0000_8010);
    bus(1'b1, IDX_POINTER1, 32'h0000_0010);
    bus(1'b1, IDX_ACC, 32'h0000_0011);
    run({9'h0, FILE_WINDOW0, 16'h0005});
    chk(cyc, 32'h0000_0002);
    rdchk(12'h010, 32'h0000_0044);
    run({9'h0, FILE_WINDOW1, 16'h0001});
    chk(cyc, 32'h0000_0001);
    rdchk(IDX_ACC, 32'h0000_0055);
    // Pointer aimed at a window itself: reads zero, writes dropped
    bus(1'b1, 12'h001, 32'h0000_0022);
    bus(1'b1, IDX_POINTER0, 32'h0000_0001);
    rdchk(IDX_WINDOW0, 32'h0000_0000);
    bus(1'b1, IDX_WINDOW0, 32'h0000_0099);
    rdchk(12'h001, 32'h0000_0022);
    run({9'h0, FILE_WINDOW0, 16'h0001});
    rdchk(IDX_ACC, 32'h0000_0055);
    $display("indirect window test done");
    test_done();
  end
endmodule : apalu_core_test
